// ==== core/at3_timer.sv ====
// third timer: 16-bit auto-reload or two 8-bit auto-reload counters with
// overflow flags, register access on the special-function-register bus.
// assumes clk is the system clock; ext_osc comes from another clock domain.
// a write to a count byte wins over the increment of that byte in the same clock.
// reading both count bytes of a running 16-bit counter may see a carry between reads.
//
// Function
// - split bit 0 gives one 16-bit counter, 1 gives two 8-bit counters.
// - 16-bit wrap from ffff loads the reload pair and sets high flag.
// - 16-bit mode: every full overflow requests interrupt when enabled.
// - 16-bit mode: low-byte wrap also interrupts when low-byte enable set.
// - split mode: each byte reloads from its own reload byte on overflow.
// - run bit gates whole 16-bit counter; in split only high byte.
// - per byte in split mode (16-bit uses the low select only): system clock if select set, else divide-12 or ext/8.
// - external divide-by-8 tick is synchronised to the system clock.
// - split mode: each byte's wrap sets its own overflow flag.
// - split: high overflow interrupts; with low enable, either byte does.
// - hardware never clears flags; software clears and inspects both.
// - low flag sets on every low-byte wrap in either mode.
// - control bits four and one read zero and ignore writes.
// - count bytes form one counter in 16-bit mode, separate in split.
module at3_timer (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic high_byte_clock_select,
    input wire logic low_byte_clock_select,
    input wire logic timer_interrupt_enable,
    input wire logic ext_osc,
    output logic [7:0] sfr_rdata,
    output logic irq
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic high_overflow_flag;
        logic low_overflow_flag;
        logic low_byte_interrupt_enable;
        logic split_mode_select;
        logic run_control;
        logic external_clock_select;
        logic [7:0] reload_low;
        logic [7:0] reload_high;
        logic [7:0] count_low;
        logic [7:0] count_high;
        logic [3:0] sys_div;
        logic ext_meta;
        logic ext_sync;
        logic ext_prev;
        logic [2:0] ext_div;
        logic ext_tick;
        logic [7:0] rdata;
        logic irq;
    } at3_state_t;

    at3_state_t s;
    at3_state_t next_s;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    logic sys_tick;
    logic ext_step;
    logic ext_div_tick;
    logic [3:0] sys_div_next;
    logic [2:0] ext_div_next;
    logic tick_low;
    logic tick_high;
    logic low_wrap;
    logic high_wrap;
    logic [7:0] low_plus_one;
    logic [7:0] high_plus_one;
    logic [7:0] low_stepped;
    logic [7:0] high_stepped;
    logic inc_low;
    logic inc_high;
    logic set_low_flag;
    logic set_high_flag;
    logic wr_ctl;
    logic [7:0] ctl_read;

    assign sfr_rdata = s.rdata;
    assign irq = s.irq;

    // ------------------------------------------------------------------
    // clock source dividers
    // ------------------------------------------------------------------
    // divide-by-12 runs free from reset, so its phase is unrelated to writes
    at3_modulo_step #(
        .WIDTH(4),
        .COUNT(at3_pkg::SYS_DIVIDE)
    ) i_sys_divider (
        .count(s.sys_div),
        .step(1'b1),
        .next_count(sys_div_next),
        .tick(sys_tick)
    );

    // one step per rising edge of the synchronised oscillator
    assign ext_step = s.ext_sync && !s.ext_prev;

    at3_modulo_step #(
        .WIDTH(3),
        .COUNT(at3_pkg::EXT_DIVIDE)
    ) i_ext_divider (
        .count(s.ext_div),
        .step(ext_step),
        .next_count(ext_div_next),
        .tick(ext_div_tick)
    );

    // ------------------------------------------------------------------
    // byte steppers, shared by both modes
    // ------------------------------------------------------------------
    at3_byte_step #(
        .WIDTH(8),
        .MAX(at3_pkg::BYTE_MAX)
    ) i_low_step (
        .count(s.count_low),
        .reload(s.reload_low),
        .wrap(low_wrap),
        .plus_one(low_plus_one),
        .stepped(low_stepped)
    );

    at3_byte_step #(
        .WIDTH(8),
        .MAX(at3_pkg::BYTE_MAX)
    ) i_high_step (
        .count(s.count_high),
        .reload(s.reload_high),
        .wrap(high_wrap),
        .plus_one(high_plus_one),
        .stepped(high_stepped)
    );

    always_comb begin
        next_s = s;
        wr_ctl = sfr_wr && (sfr_addr == at3_pkg::ADDR_CONTROL);

        // --------------------------------------------------------------
        // clock sources
        // --------------------------------------------------------------
        next_s.sys_div = sys_div_next;
        // first stage feeds only the second stage
        next_s.ext_meta = ext_osc;
        next_s.ext_sync = s.ext_meta;
        next_s.ext_prev = s.ext_sync;
        next_s.ext_div = ext_div_next;
        next_s.ext_tick = ext_div_tick;
        tick_low = low_byte_clock_select ? 1'b1
                 : (s.external_clock_select ? s.ext_tick : sys_tick);
        tick_high = high_byte_clock_select ? 1'b1
                  : (s.external_clock_select ? s.ext_tick : sys_tick);

        // --------------------------------------------------------------
        // counting
        // --------------------------------------------------------------
        set_low_flag = 1'b0;
        set_high_flag = 1'b0;
        if (s.split_mode_select) begin
            inc_low = tick_low;
            inc_high = tick_high && s.run_control;
            if (inc_low) begin
                next_s.count_low = low_stepped;
                set_low_flag = low_wrap;
            end
            if (inc_high) begin
                next_s.count_high = high_stepped;
                set_high_flag = high_wrap;
            end
        end else begin
            inc_low = tick_low && s.run_control;
            inc_high = inc_low && low_wrap;
            if (inc_low) begin
                set_low_flag = low_wrap;
                if (low_wrap && high_wrap) begin
                    next_s.count_low = s.reload_low;
                    next_s.count_high = s.reload_high;
                    set_high_flag = 1'b1;
                end else begin
                    next_s.count_low = low_plus_one;
                    next_s.count_high = inc_high ? high_plus_one : s.count_high;
                end
            end
        end

        // --------------------------------------------------------------
        // register writes; a write wins over counting for its byte
        // --------------------------------------------------------------
        if (sfr_wr) begin
            unique case (sfr_addr)
                at3_pkg::ADDR_RELOAD_LOW: next_s.reload_low = sfr_wdata;
                at3_pkg::ADDR_RELOAD_HIGH: next_s.reload_high = sfr_wdata;
                at3_pkg::ADDR_COUNT_LOW: next_s.count_low = sfr_wdata;
                at3_pkg::ADDR_COUNT_HIGH: next_s.count_high = sfr_wdata;
                at3_pkg::ADDR_CONTROL: begin
                    // bits four and one are not stored
                    next_s.low_byte_interrupt_enable = sfr_wdata[at3_pkg::BIT_LOW_INT_ENABLE];
                    next_s.split_mode_select = sfr_wdata[at3_pkg::BIT_SPLIT];
                    next_s.run_control = sfr_wdata[at3_pkg::BIT_RUN];
                    next_s.external_clock_select = sfr_wdata[at3_pkg::BIT_EXT_CLOCK];
                end
                default: begin
                end
            endcase
        end
        // flags only clear by write; a same-cycle set wins
        next_s.high_overflow_flag = set_high_flag
            || (wr_ctl ? sfr_wdata[at3_pkg::BIT_HIGH_OVERFLOW] : s.high_overflow_flag);
        next_s.low_overflow_flag = set_low_flag
            || (wr_ctl ? sfr_wdata[at3_pkg::BIT_LOW_OVERFLOW] : s.low_overflow_flag);

        // --------------------------------------------------------------
        // interrupt request and read data
        // --------------------------------------------------------------
        // irq follows the enabled flags, so it stays up until software clears them or an enable drops
        next_s.irq = timer_interrupt_enable && (next_s.high_overflow_flag
            || (next_s.low_byte_interrupt_enable && next_s.low_overflow_flag));

        ctl_read = 8'h00;
        ctl_read[at3_pkg::BIT_HIGH_OVERFLOW] = s.high_overflow_flag;
        ctl_read[at3_pkg::BIT_LOW_OVERFLOW] = s.low_overflow_flag;
        ctl_read[at3_pkg::BIT_LOW_INT_ENABLE] = s.low_byte_interrupt_enable;
        ctl_read[at3_pkg::BIT_SPLIT] = s.split_mode_select;
        ctl_read[at3_pkg::BIT_RUN] = s.run_control;
        ctl_read[at3_pkg::BIT_EXT_CLOCK] = s.external_clock_select;
        unique case (sfr_addr)
            at3_pkg::ADDR_CONTROL: next_s.rdata = ctl_read;
            at3_pkg::ADDR_RELOAD_LOW: next_s.rdata = s.reload_low;
            at3_pkg::ADDR_RELOAD_HIGH: next_s.rdata = s.reload_high;
            at3_pkg::ADDR_COUNT_LOW: next_s.rdata = s.count_low;
            at3_pkg::ADDR_COUNT_HIGH: next_s.rdata = s.count_high;
            default: next_s.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '0;
            s.high_overflow_flag <= at3_pkg::RESET_CONTROL[at3_pkg::BIT_HIGH_OVERFLOW];
            s.low_overflow_flag <= at3_pkg::RESET_CONTROL[at3_pkg::BIT_LOW_OVERFLOW];
            s.low_byte_interrupt_enable <= at3_pkg::RESET_CONTROL[at3_pkg::BIT_LOW_INT_ENABLE];
            s.split_mode_select <= at3_pkg::RESET_CONTROL[at3_pkg::BIT_SPLIT];
            s.run_control <= at3_pkg::RESET_CONTROL[at3_pkg::BIT_RUN];
            s.external_clock_select <= at3_pkg::RESET_CONTROL[at3_pkg::BIT_EXT_CLOCK];
            s.reload_low <= at3_pkg::RESET_RELOAD;
            s.reload_high <= at3_pkg::RESET_RELOAD;
            s.count_low <= at3_pkg::RESET_COUNT;
            s.count_high <= at3_pkg::RESET_COUNT;
        end else begin
            s <= next_s;
        end
    end
endmodule

// ----------------------------------------------------------------------
// one counter byte: increment, wrap detect and auto-reload value
// ----------------------------------------------------------------------
module at3_byte_step #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] MAX = {WIDTH{1'b1}}
) (
    input wire logic [WIDTH-1:0] count,
    input wire logic [WIDTH-1:0] reload,
    output logic wrap,
    output logic [WIDTH-1:0] plus_one,
    output logic [WIDTH-1:0] stepped
);
    assign wrap = (count == MAX);
    assign plus_one = count + WIDTH'(1);
    // the reload value is read at the wrap itself, never latched early
    assign stepped = wrap ? reload : plus_one;
endmodule

// ----------------------------------------------------------------------
// modulo counter step: next count and a tick on the last count
// ----------------------------------------------------------------------
module at3_modulo_step #(
    parameter int WIDTH = 4,
    parameter int COUNT = 12
) (
    input wire logic [WIDTH-1:0] count,
    input wire logic step,
    output logic [WIDTH-1:0] next_count,
    output logic tick
);
    localparam logic [WIDTH-1:0] LAST = WIDTH'(COUNT - 1);

    assign tick = step && (count == LAST);
    always_comb begin
        next_count = count;
        if (tick) begin
            next_count = {WIDTH{1'b0}};
        end else if (step) begin
            next_count = count + WIDTH'(1);
        end
    end
endmodule

// ==== core/at3_pkg.sv ====
// package of the third auto-reload timer: register offsets, control bit
// positions, reset values and prescaler figures.
// assumes the register offsets are the special-function-register addresses.
package at3_pkg;
    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL = 8'h91;
    localparam logic [7:0] ADDR_RELOAD_LOW = 8'h92;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h94;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h95;

    // ------------------------------------------------------------------
    // control register bit positions
    // ------------------------------------------------------------------
    localparam int BIT_HIGH_OVERFLOW = 7;
    localparam int BIT_LOW_OVERFLOW = 6;
    localparam int BIT_LOW_INT_ENABLE = 5;
    localparam int BIT_SPLIT = 3;
    localparam int BIT_RUN = 2;
    localparam int BIT_EXT_CLOCK = 0;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RESET_CONTROL = 8'h00;
    localparam logic [7:0] RESET_RELOAD = 8'h00;
    localparam logic [7:0] RESET_COUNT = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hFF;

    // ------------------------------------------------------------------
    // prescalers
    // ------------------------------------------------------------------
    localparam int SYS_DIVIDE = 12;
    localparam int EXT_DIVIDE = 8;
endpackage

// ==== test/at3_timer_asserts.sv ====
// checker of the third auto-reload timer, watching its ports only.
// assumes read data lags the address by one clock.
module at3_timer_asserts (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic high_byte_clock_select,
    input wire logic low_byte_clock_select,
    input wire logic timer_interrupt_enable,
    input wire logic ext_osc,
    input wire logic [7:0] sfr_rdata,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    AST_IRQ_GATED: assert property (!timer_interrupt_enable |=> !irq)
        else $error("irq without timer interrupt enable");
    AST_UNUSED_ZERO: assert property (sfr_addr == 8'h91 |=> sfr_rdata[4] == 1'b0 && sfr_rdata[1] == 1'b0)
        else $error("unused control bits not zero");
    AST_UNMAPPED_ZERO: assert property (sfr_addr < 8'h91 || sfr_addr > 8'h95 |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_RELOAD_BACK: assert property (sfr_wr && sfr_addr == 8'h93 ##1 sfr_addr == 8'h93 |=> sfr_rdata == $past(sfr_wdata, 2))
        else $error("reload high readback wrong");
    AST_CONTROL_BACK: assert property (sfr_wr && sfr_addr == 8'h91 ##1 sfr_addr == 8'h91
        |=> (sfr_rdata & 8'h2d) == ($past(sfr_wdata, 2) & 8'h2d))
        else $error("control readback wrong");
    AST_HIGH_STICKY: assert property (sfr_addr == 8'h91 && !sfr_wr ##1 sfr_addr == 8'h91 && sfr_rdata[7] |=> sfr_rdata[7])
        else $error("high flag cleared by hardware");
    AST_LOW_STICKY: assert property (sfr_addr == 8'h91 && !sfr_wr ##1 sfr_addr == 8'h91 && sfr_rdata[6] |=> sfr_rdata[6])
        else $error("low flag cleared by hardware");
    AST_IRQ_HOLDS: assert property (irq && timer_interrupt_enable && !(sfr_wr && sfr_addr == 8'h91) |=> irq)
        else $error("irq dropped without flag write");
endmodule
bind at3_timer at3_timer_asserts i_asserts (.clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .high_byte_clock_select(high_byte_clock_select),
    .low_byte_clock_select(low_byte_clock_select), .timer_interrupt_enable(timer_interrupt_enable),
    .ext_osc(ext_osc), .sfr_rdata(sfr_rdata), .irq(irq));

// ==== test/at3_timer_bench.sv ====
// bench of the third auto-reload timer: register tasks and scenarios.
// assumes core/at3_pkg.sv, core/at3_timer.sv and the checker compile first.
module at3_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset = 1, wr = 0, hsel = 0, lsel = 1, ien = 1, osc = 0, irq;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    int n_mismatch = 0, checked = 0;
    always #4 clk = ~clk;
    always #10 osc = ~osc;
    at3_timer i_dut (.clk(clk), .reset(reset), .sfr_addr(addr), .sfr_wr(wr), .sfr_wdata(wdata),
        .high_byte_clock_select(hsel), .low_byte_clock_select(lsel), .timer_interrupt_enable(ien),
        .ext_osc(osc), .sfr_rdata(rdata), .irq(irq));
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {addr, wr, wdata} = {a, 1'b1, d};
        @(negedge clk);
        wr = 0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
        idle(1);
        addr = a;
        idle(1);
        checked++;
        if ((rdata & m) !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: reg %h read %h", $time, a, rdata);
        end
    endtask
    task automatic chk_irq(input logic e);
        checked++;
        if (irq !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: irq %b", $time, irq);
        end
    endtask
    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        idle(10);
        reset = 0;
        for (int a = 8'h90; a < 8'h97; a++) chk(8'(a), 8'h00);
        w(8'h91, 8'h12);
        chk(8'h91, 8'h00);
        // ------------------------------------------------------------------
        // 16-bit mode on the system clock
        // ------------------------------------------------------------------
        w(8'h92, 8'h34);
        w(8'h93, 8'h12);
        w(8'h94, 8'hfe);
        w(8'h95, 8'hff);
        chk(8'h94, 8'hfe);
        w(8'h91, 8'h04);
        idle(2);
        chk(8'h91, 8'hc4);
        chk_irq(1);
        chk(8'h91, 8'hc4);
        chk(8'h95, 8'h12);
        ien = 0;
        idle(2);
        chk_irq(0);
        ien = 1;
        w(8'h91, 8'h00);
        chk(8'h91, 8'h00);
        chk_irq(0);
        w(8'h94, 8'hfe);
        w(8'h91, 8'h24);
        idle(2);
        chk(8'h91, 8'h64);
        chk_irq(1);
        chk(8'h95, 8'h13);
        w(8'h91, 8'h00);
        // ------------------------------------------------------------------
        // split mode
        // ------------------------------------------------------------------
        w(8'h95, 8'h55);
        w(8'h92, 8'h80);
        w(8'h93, 8'h40);
        w(8'h94, 8'hfe);
        w(8'h91, 8'h08);
        idle(4);
        chk(8'h91, 8'h48);
        chk_irq(0);
        chk(8'h95, 8'h55);
        chk(8'h94, 8'h80, 8'hf0);
        hsel = 1;
        w(8'h95, 8'hff);
        w(8'h91, 8'h0c);
        idle(2);
        chk(8'h91, 8'h8c);
        chk(8'h95, 8'h40, 8'hf0);
        chk_irq(1);
        w(8'h91, 8'h28);
        idle(130);
        chk(8'h91, 8'h68);
        chk_irq(1);
        // ------------------------------------------------------------------
        // divided sources on the low byte
        // ------------------------------------------------------------------
        lsel = 0;
        w(8'h94, 8'hfb);
        w(8'h91, 8'h08);
        idle(30);
        chk(8'h91, 8'h08);
        idle(40);
        chk(8'h91, 8'h48);
        w(8'h91, 8'h09);
        w(8'h94, 8'hfe);
        idle(4);
        chk(8'h91, 8'h09);
        idle(60);
        chk(8'h91, 8'h49);
        print_verdict();
    end
endmodule
